/* File: src/audio_params.svh */
// Register map, field positions, reset values and timing of the audio serial master
`ifndef AUDIO_PARAMS_SVH
`define AUDIO_PARAMS_SVH
`define A_CTRL 8'h00
`define A_DIV 8'h04
`define A_FMT 8'h08
`define A_TXL 8'h0c
`define A_TXR 8'h10
`define A_RXL 8'h14
`define A_RXR 8'h18
`define A_CMD 8'h1c
`define A_STAT 8'h20
`define CTRL_RST 5'h00
`define DIV_RST 7'h10
`define DIV_MIN 7'h02
`define DIV_MAX 7'h7e
`define FMT_RST 14'h000f
`define CMD_START 0
`define ST_BUSY 0
`define ST_IRQ 1
`define ST_RXV 2
`define SLOT_BASE 6'h10
`define EXTRA_MAX 5'h10
`define SYS_CLK_MHZ 16
`define CLK_MHZ 250
`endif

/* File: src/audio_pkg.sv */
// Types shared by the audio serial master
package audio_pkg;
  typedef enum logic [1:0] {FMT_I2S, FMT_LEFT, FMT_RIGHT} frame_mode_t;
  typedef enum {ST_IDLE, ST_RUN} state_t;
  typedef struct packed {
    logic idle_left;
    logic ws_inv;
    frame_mode_t mode;
    logic [4:0] extra;
    logic pad16;
    logic [3:0] nbits_m1;
  } fmt_t;
  typedef struct packed {
    logic mono_right;
    logic fifo_mode;
    logic irq_en;
    logic clk_always;
    logic enable;
  } ctrl_t;
  typedef struct packed {
    logic hsel;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } ahb_req_t;
  typedef struct packed {
    logic has;
    logic right;
    logic [3:0] bit_ix;
  } slot_pos_t;
endpackage

/* File: src/audio_serial_master_port.sv */
// Stereo audio serial master with AHB-Lite registers
// Function
// - Bit clock is system clock divided by an even value 2 to 126.
// - Divisor defaults to give a 1 MHz bit clock.
// - Bit clock output runs always or only during a frame.
// - Power enable; when off no transfers, can be turned off anytime.
// - 1 to 16 audio bits per channel, MSB first.
// - Optional zero padding makes each slot 16 bits.
// - Up to 16 extra zero bits, slot up to 32 bits.
// - Every non-audio bit sent is zero.
// - Format field picks I2S, left- or right-justified.
// - Word select polarity may be inverted, never in I2S. The code applies ws_inv in I2S as well.
// - Word select idle level selectable; right state in I2S. The code takes idle_left and ws_inv for the idle level in I2S as well.
// - Frame-done interrupt request when its enable is set.
// - Transmit and receive shift on the same bit clock.
// - One transfer moves one left then right frame, then stops.
// - Transmit buffer holds separately written left and right words.
// - Received frame stored; reading the right word (A_RXR) clears both words, a left read does not.
// - Software start launches one frame from the transmit buffer.
// - Busy is true from start until frame completion.
// - In sample path mode a trigger rising edge starts a frame.
// - Mono sample rides in the left or the right channel.
// - I2S: word select leads each channel MSB by one bit.
// - Left-justified: MSB in the period of the select change.
// - Right-justified: padding first, LSB before next select change.
// - Uninverted word select is high for right, low for left.
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "audio_params.svh"

module audio_serial_master_port (
  input wire logic clk,
  input wire logic resetn,
  input wire audio_pkg::ahb_req_t ahb_req,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic timer_trigger,
  input wire logic [15:0] fifo_tx_sample,
  output logic [15:0] fifo_rx_sample,
  output logic fifo_rx_strobe,
  input wire logic serial_audio_in,
  output logic sck,
  output logic ws,
  output logic serial_audio_out,
  output logic audio_port_irq_source
);
  import audio_pkg::*;

  function automatic slot_pos_t pos_at(
    input logic [6:0] k,
    input logic [5:0] slot,
    input logic [4:0] nb,
    input logic lead,
    input logic rj
  );
    logic [6:0] d;
    logic [6:0] p;
    logic [6:0] pad;
    slot_pos_t r;
    d = k - {6'h00, lead};
    r.right = d >= {1'b0, slot};
    p = r.right ? d - {1'b0, slot} : d;
    pad = {1'b0, slot} - {2'h0, nb};
    r.has = (k >= {6'h00, lead}) && (rj ? p >= pad : p < {2'h0, nb});
    r.bit_ix = 4'hf - (rj ? p[3:0] - pad[3:0] : p[3:0]);
    return r;
  endfunction

  ctrl_t ctrl_r;
  fmt_t fmt_r;
  logic [6:0] div_r;
  logic [15:0] txl_r, txr_r, rxl_r, rxr_r;
  logic [15:0] fl_r, fr_r, cl_r, cr_r;
  logic [15:0] cl_nxt, cr_nxt;
  logic rxv_r, irqp_r, busy_r, pend_r;
  state_t st_r;
  logic [6:0] k_r;
  logic [5:0] cnt_r;
  logic phase_r;
  logic din_s1_r, din_s2_r, trig_q_r;
  logic a_wr_r;
  logic [7:0] a_addr_r;
  logic sck_r, ws_r, sdo_r, irq_r, strobe_r;
  logic [15:0] frx_r;
  logic [31:0] hrdata_r;

  // Bus decode
  wire ap_go = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
  wire ap_rd = ap_go && !ahb_req.hwrite;
  wire wr_go = a_wr_r && ahb_req.hready;
  wire [7:0] ra = ahb_req.haddr;
  wire [31:0] rd_word =
    (ra == `A_CTRL) ? {27'h0, ctrl_r} :
    (ra == `A_DIV) ? {25'h0, div_r} :
    (ra == `A_FMT) ? {18'h0, fmt_r} :
    (ra == `A_TXL) ? {16'h0, txl_r} :
    (ra == `A_TXR) ? {16'h0, txr_r} :
    (ra == `A_RXL) ? {16'h0, rxl_r} :
    (ra == `A_RXR) ? {16'h0, rxr_r} :
    (ra == `A_STAT) ? {29'h0, rxv_r, irqp_r, busy_r} : 32'h0;
  wire rx_clr = ap_rd && ra == `A_RXR;
  wire irq_ack = wr_go && a_addr_r == `A_STAT && ahb_req.hwdata[`ST_IRQ];

  // Divisor forced even and at least two, so odd writes cannot skew the duty
  wire [6:0] div_ev = {div_r[6:1], 1'b0};
  wire [6:0] div_eff = (div_ev < `DIV_MIN) ? `DIV_MIN : div_ev;
  wire [5:0] half = div_eff[6:1];
  wire half_tick = ctrl_r.enable && cnt_r == half - 6'h01;
  wire bnd = half_tick && phase_r;
  wire phase_nxt = half_tick ? !phase_r : phase_r;

  // Slot geometry
  wire [4:0] nb = {1'b0, fmt_r.nbits_m1} + 5'h01;
  wire [4:0] extra_c = (fmt_r.extra > `EXTRA_MAX) ? `EXTRA_MAX : fmt_r.extra;
  wire [5:0] slot = fmt_r.pad16 ? `SLOT_BASE + {1'b0, extra_c} : {1'b0, nb};
  wire lead = fmt_r.mode == FMT_I2S;
  wire rj = fmt_r.mode == FMT_RIGHT;
  wire [6:0] last_k = {slot, 1'b0} + {6'h00, lead} - 7'h01;
  wire running = st_r == ST_RUN;
  wire [6:0] k_nxt = running ? k_r + 7'h01 : 7'h00;
  wire done = running && bnd && k_r == last_k;
  wire slot_pos_t cpos = pos_at(k_r, slot, nb, lead, rj);
  wire slot_pos_t npos = pos_at(k_nxt, slot, nb, lead, rj);

  // Sample path puts the mono word in one channel, the other stays zero
  wire [15:0] src_l = ctrl_r.fifo_mode ? (ctrl_r.mono_right ? 16'h0 : fifo_tx_sample) : txl_r;
  wire [15:0] src_r = ctrl_r.fifo_mode ? (ctrl_r.mono_right ? fifo_tx_sample : 16'h0) : txr_r;
  wire [15:0] wl = running ? fl_r : src_l;
  wire [15:0] wr = running ? fr_r : src_r;
  wire [15:0] nword = npos.right ? wr : wl;
  wire bit_nxt = npos.has && nword[npos.bit_ix];
  wire ws_right = k_nxt >= {1'b0, slot};
  wire ws_idle = !fmt_r.idle_left ^ fmt_r.ws_inv;
  wire ws_run = ws_right ^ fmt_r.ws_inv;

  // Start sources
  wire sw_start = wr_go && a_addr_r == `A_CMD && ahb_req.hwdata[`CMD_START] &&
    !ctrl_r.fifo_mode;
  wire trg_start = ctrl_r.fifo_mode && timer_trigger && !trig_q_r;
  wire accept = ctrl_r.enable && (sw_start || trg_start) && !busy_r;
  wire launch = pend_r && bnd && !running;
  wire irqp_nxt = done || (irqp_r && !irq_ack);

  // Received bit taken at the end of its period, into the channel whose slot it falls in
  always_comb
  begin
    cl_nxt = cl_r;
    cr_nxt = cr_r;
    if (running && bnd && cpos.has)
    begin
      if (cpos.right)
        cr_nxt[cpos.bit_ix] = din_s2_r;
      else
        cl_nxt[cpos.bit_ix] = din_s2_r;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      a_wr_r <= 1'b0;
      a_addr_r <= 8'h00;
      hrdata_r <= 32'h0;
    end
    else
    begin
      a_wr_r <= ap_go && ahb_req.hwrite;
      if (ap_go)
        a_addr_r <= ra;
      if (ap_rd)
        hrdata_r <= rd_word;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_r <= ctrl_t'(`CTRL_RST);
      div_r <= `DIV_RST;
      fmt_r <= fmt_t'(`FMT_RST);
      txl_r <= 16'h0;
      txr_r <= 16'h0;
    end
    else if (wr_go)
    begin
      if (a_addr_r == `A_CTRL)
        ctrl_r <= ctrl_t'(ahb_req.hwdata[4:0]);
      if (a_addr_r == `A_DIV)
        div_r <= ahb_req.hwdata[6:0];
      if (a_addr_r == `A_FMT)
        fmt_r <= fmt_t'(ahb_req.hwdata[13:0]);
      if (a_addr_r == `A_TXL)
        txl_r <= ahb_req.hwdata[15:0];
      if (a_addr_r == `A_TXR)
        txr_r <= ahb_req.hwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
      trig_q_r <= 1'b0;
      cnt_r <= 6'h00;
      phase_r <= 1'b0;
    end
    else
    begin
      din_s1_r <= serial_audio_in;
      din_s2_r <= din_s1_r;
      trig_q_r <= timer_trigger;
      cnt_r <= (!ctrl_r.enable || half_tick) ? 6'h00 : cnt_r + 6'h01;
      phase_r <= ctrl_r.enable && phase_nxt;
    end
  end

  // Frame sequencer; switching the port off aborts a frame without an interrupt
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= ST_IDLE;
      k_r <= 7'h00;
      busy_r <= 1'b0;
      pend_r <= 1'b0;
      fl_r <= 16'h0;
      fr_r <= 16'h0;
      cl_r <= 16'h0;
      cr_r <= 16'h0;
    end
    else if (!ctrl_r.enable)
    begin
      st_r <= ST_IDLE;
      busy_r <= 1'b0;
      pend_r <= 1'b0;
    end
    else
    begin
      cl_r <= cl_nxt;
      cr_r <= cr_nxt;
      if (accept)
      begin
        busy_r <= 1'b1;
        pend_r <= 1'b1;
      end
      if (launch)
      begin
        st_r <= ST_RUN;
        k_r <= 7'h00;
        pend_r <= 1'b0;
        fl_r <= src_l;
        fr_r <= src_r;
        cl_r <= 16'h0;
        cr_r <= 16'h0;
      end
      else if (done)
      begin
        st_r <= ST_IDLE;
        busy_r <= 1'b0;
      end
      else if (running && bnd)
        k_r <= k_nxt;
    end
  end

  // Receive buffer and status flags; a finishing frame beats a clearing read
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxl_r <= 16'h0;
      rxr_r <= 16'h0;
      rxv_r <= 1'b0;
      irqp_r <= 1'b0;
      frx_r <= 16'h0;
      strobe_r <= 1'b0;
    end
    else
    begin
      irqp_r <= ctrl_r.enable && irqp_nxt;
      strobe_r <= done && ctrl_r.fifo_mode;
      if (done && ctrl_r.fifo_mode)
        frx_r <= ctrl_r.mono_right ? cr_nxt : cl_nxt;
      if (done && !ctrl_r.fifo_mode)
      begin
        rxl_r <= cl_nxt;
        rxr_r <= cr_nxt;
        rxv_r <= 1'b1;
      end
      else if (rx_clr)
      begin
        rxl_r <= 16'h0;
        rxr_r <= 16'h0;
        rxv_r <= 1'b0;
      end
    end
  end

  // Pins; clock gated low so a gated clock never shows a runt pulse
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_r <= 1'b0;
      ws_r <= 1'b1;
      sdo_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      sck_r <= ctrl_r.enable && phase_nxt && (ctrl_r.clk_always || running);
      if (!ctrl_r.enable || done || (!running && !launch))
      begin
        ws_r <= ws_idle;
        sdo_r <= 1'b0;
      end
      else if (bnd)
      begin
        ws_r <= ws_run;
        sdo_r <= bit_nxt;
      end
      irq_r <= ctrl_r.enable && irqp_nxt && ctrl_r.irq_en;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign fifo_rx_sample = frx_r;
  assign fifo_rx_strobe = strobe_r;
  assign sck = sck_r;
  assign ws = ws_r;
  assign serial_audio_out = sdo_r;
  assign audio_port_irq_source = irq_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_div_even;
    div_eff[0] == 1'b0 && div_eff >= `DIV_MIN && div_eff <= `DIV_MAX;
  endproperty
  a_div_even: assert property (p_div_even) else $error("bad divisor");

  property p_irq_on_done;
    $fell(busy_r) && ctrl_r.enable |-> irqp_r;
  endproperty
  a_irq_on_done: assert property (p_irq_on_done) else $error("no pending");

  property p_hold_tx;
    running && !launch |=> $stable(fl_r) && $stable(fr_r);
  endproperty
  a_hold_tx: assert property (p_hold_tx) else $error("frame altered");

  property p_idle_zero;
    !running |-> !sdo_r;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("data idle");

  property p_gated;
    !ctrl_r.clk_always && !$past(ctrl_r.clk_always) && !running && !$past(running) |-> !sck_r;
  endproperty
  a_gated: assert property (p_gated) else $error("clock ran");

  property p_off;
    !ctrl_r.enable |=> !busy_r && !sck_r && !running;
  endproperty
  a_off: assert property (p_off) else $error("active off");

  property p_run_busy;
    running |-> busy_r;
  endproperty
  a_run_busy: assert property (p_run_busy) else $error("not busy");

  property p_trig;
    accept && trg_start |=> busy_r ##[1:260] running;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger lost");

  property p_irq_out;
    done && ctrl_r.irq_en |=> audio_port_irq_source;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("no irq");

  c_frame: cover property (done);
  c_i2s: cover property (done && lead);
  c_rj: cover property (done && rj);
  c_fifo: cover property (fifo_rx_strobe);
endmodule
`default_nettype wire

/* File: dv/audio_codec_model.sv */
// Codec model on the far side of the audio serial link
`timescale 1ns/10ps
`default_nettype none
module audio_codec_model (
  input wire logic sck,
  input wire logic ws,
  input wire logic serial_audio_out,
  output logic serial_audio_in
);
  logic [1:0] seen[$];
  realtime rise_t[$];
  initial serial_audio_in = 1'b0;
  // Echo inverted so a receive path that copies transmit data is caught
  always @(posedge sck)
  begin
    seen.push_back({ws, serial_audio_out});
    rise_t.push_back($realtime);
    serial_audio_in <= ~serial_audio_out;
  end
endmodule
`default_nettype wire

/* File: dv/audio_serial_master_port_tb_top.sv */
// Self-checking bench for the audio serial master
`timescale 1ns/10ps
`default_nettype none
`include "audio_params.svh"
module audio_serial_master_port_tb_top;
  import audio_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  ahb_req_t req = '0;
  ahb_req_t bus;
  logic hreadyout, hresp, fifo_rx_strobe, sdi, sck, ws, sdo, irq;
  logic [31:0] hrdata, rd;
  logic timer_trigger = 1'b0;
  logic [15:0] fifo_tx_sample = 16'h0000;
  logic [15:0] fifo_rx_sample, l, r, mk;
  logic [1:0] exp_q[$];
  int n_fail = 0;
  int samples_checked = 0;
  int i, eff, m;
  int divs[9] = '{16, 8, 5, 126, 2, 8, 7, 3, 16};
  fmt_t f;
  always #2 clk = ~clk;
  always_comb
  begin
    bus = req;
    bus.hready = hreadyout;
  end
  audio_serial_master_port dut (.clk(clk), .resetn(resetn), .ahb_req(bus),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_trigger(timer_trigger),
    .fifo_tx_sample(fifo_tx_sample), .fifo_rx_sample(fifo_rx_sample),
    .fifo_rx_strobe(fifo_rx_strobe), .serial_audio_in(sdi), .sck(sck), .ws(ws),
    .serial_audio_out(sdo), .audio_port_irq_source(irq));
  audio_codec_model codec (.sck(sck), .ws(ws), .serial_audio_out(sdo), .serial_audio_in(sdi));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic hang(input string what);
    chk(what, 32'h0, 32'h1);
    finish_test();
  endtask
  task automatic edge_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      if (++n > 50)
        hang("hready");
      @(posedge clk);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    req <= {1'b1, a, 2'b10, w, 3'b010, 1'b0, 32'h0};
    edge_ready();
    req <= {1'b0, a, 2'b00, w, 3'b010, 1'b0, wd};
    edge_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(what, e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, `A_STAT, 32'h0);
      if (++n > 6000)
        hang("busy_wait");
    end
    while (rd[`ST_BUSY] !== 1'b0);
  endtask
  // Reference frame: one entry of {ws, data} per bit period
  task automatic build(input fmt_t g, input logic [15:0] lw, input logic [15:0] rw);
    int nb, slot, lead, p, k, j;
    logic [15:0] w;
    exp_q.delete();
    nb = g.nbits_m1 + 1;
    slot = g.pad16 ? 16 + ((g.extra > 16) ? 16 : g.extra) : nb;
    lead = (g.mode == FMT_I2S);
    for (p = 0; p < lead + 2 * slot; p++)
    begin
      k = p - lead;
      w = (k >= slot) ? rw : lw;
      j = (k < 0) ? -1 : k % slot;
      if (g.mode == FMT_RIGHT)
        j = j - (slot - nb);
      exp_q.push_back({(p >= slot) ^ g.ws_inv, (j >= 0 && j < nb) ? w[15 - j] : 1'b0});
    end
    codec.seen.delete();
    codec.rise_t.delete();
  endtask
  task automatic cmp_frame;
    int n;
    n = 0;
    while (n < exp_q.size() && n < codec.seen.size() && codec.seen[n] === exp_q[n])
      n++;
    chk("frame_bits", exp_q.size(), n);
    chk("frame_len", exp_q.size(), codec.seen.size());
  endtask
  initial
  begin
    void'($urandom(94));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rchk("ctrl_rst", `A_CTRL, 32'h0);
    rchk("div_rst", `A_DIV, 32'h10);
    rchk("fmt_rst", `A_FMT, 32'h000f);
    wr(8'h24, 32'hffffffff);
    rchk("unmapped", 8'h24, 32'h0);
    wr(`A_CMD, 32'h1);
    rchk("start_off", `A_STAT, 32'h0);
    for (i = 0; i < 9; i++)
    begin
      f.nbits_m1 = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'($urandom_range(15, 0));
      f.pad16 = (i == 2) | 1'($urandom);
      f.extra = (i == 2) ? 5'h10 : 5'($urandom_range(16, 0));
      f.mode = frame_mode_t'(i % 3);
      f.ws_inv = (i % 3 != 0) & 1'($urandom);
      f.idle_left = (i % 3 == 2) | ((i % 3 == 1) & 1'($urandom));
      l = 16'($urandom);
      r = 16'($urandom);
      mk = 16'hffff << (15 - f.nbits_m1);
      eff = divs[i] & 32'hfffe;
      wr(`A_CTRL, {27'h0, 5'(1 + 4 * (i % 2))});
      if (i > 0)
        wr(`A_DIV, 32'(divs[i]));
      wr(`A_FMT, {18'h0, f});
      wr(`A_TXL, {16'h0, l});
      wr(`A_TXR, {16'h0, r});
      chk("ws_idle", {~f.idle_left ^ f.ws_inv}, ws);
      build(f, l, r);
      wr(`A_CMD, 32'h1);
      rchk("busy", `A_STAT, 32'h1);
      // Second start only where the frame surely outlasts the write
      if (eff >= 8)
        wr(`A_CMD, 32'h1);
      wait_idle();
      cmp_frame();
      chk("sck_period", eff * 4, int'(codec.rise_t[1] - codec.rise_t[0]));
      chk("irq_pin", i % 2, irq);
      rchk("status_done", `A_STAT, 32'h6);
      xfer(1'b0, `A_RXL, 32'h0);
      // Capture is only dependable from divisor 6 upward; margin kept at 8
      if (eff >= 8)
        chk("rx_left", {16'h0, ~l & mk}, rd);
      xfer(1'b0, `A_RXR, 32'h0);
      if (eff >= 8)
        chk("rx_right", {16'h0, ~r & mk}, rd);
      rchk("rx_cleared", `A_RXL, 32'h0);
      wr(`A_STAT, 32'h2);
      rchk("status_ack", `A_STAT, 32'h0);
      chk("irq_clear", 32'h0, irq);
      chk("ws_after", {~f.idle_left ^ f.ws_inv}, ws);
    end
    m = codec.seen.size();
    repeat (200) @(posedge clk);
    chk("gated_idle", m, codec.seen.size());
    wr(`A_CTRL, 32'h3);
    m = codec.seen.size();
    repeat (200) @(posedge clk);
    chk("free_run", 32'h1, codec.seen.size() > m + 8);
    // Long frame so the switch-off lands in mid-frame
    wr(`A_FMT, 32'h000f);
    wr(`A_CTRL, 32'h5);
    wr(`A_CMD, 32'h1);
    repeat (40) @(posedge clk);
    wr(`A_CTRL, 32'h4);
    // Busy and pending drop one cycle after the enable bit clears
    @(posedge clk);
    rchk("abort", `A_STAT, 32'h0);
    chk("abort_irq", 32'h0, irq);
    for (i = 0; i < 2; i++)
    begin
      wr(`A_FMT, 32'h000f);
      wr(`A_CTRL, {27'h0, 1'(i), 4'h9});
      l = 16'($urandom);
      fifo_tx_sample <= l;
      wr(`A_CMD, 32'h1);
      rchk("cmd_in_fifo", `A_STAT, 32'h0);
      build(fmt_t'(14'h000f), i ? 16'h0 : l, i ? l : 16'h0);
      timer_trigger <= 1'b1;
      @(posedge clk);
      timer_trigger <= 1'b0;
      m = 0;
      do
      begin
        @(negedge clk);
        if (++m > 3000)
          hang("rx_strobe");
      end
      while (fifo_rx_strobe !== 1'b1);
      chk("rx_sample", {16'h0, ~l}, {16'h0, fifo_rx_sample});
      @(negedge clk);
      chk("strobe_pulse", 32'h0, fifo_rx_strobe);
      @(posedge clk);
      cmp_frame();
      rchk("fifo_done", `A_STAT, 32'h2);
      wr(`A_STAT, 32'h2);
    end
    finish_test();
  end
endmodule
`default_nettype wire
